//--- logic/pps_top.sv
// Pushbutton power on/off sequencer
// Contract
// - Enable after button low 128 ms
// - Off press needs 32 ms plus extension
// - Valid off press lowers request, starts failsafe
// - Ignore ack and button 512 ms blanking
// - Ack still low after blanking aborts
// - Ack low releases enable within 30 us
// - Failsafe 128 ms plus extension releases
// - Ack low during failsafe releases immediately
// - Button ignored in lockout after release
// - Enable polarity selected by variant
// - Lockout lasts 256 ms
// - Button high resets debounce timer
// - Reset leaves enable released, request inactive
`timescale 1ns/1ps
module pps_top #(
    parameter bit ACTIVE_LOW_EN = 1'b0,
    parameter int unsigned ON_DEB_US = pps_pkg::ON_DEBOUNCE_US,
    parameter int unsigned OFF_DEB_US = pps_pkg::OFF_DEBOUNCE_US,
    parameter int unsigned BLANK_T_US = pps_pkg::BLANK_US,
    parameter int unsigned FAILSAFE_T_US = pps_pkg::FAILSAFE_US,
    parameter int unsigned LOCKOUT_T_US = pps_pkg::LOCKOUT_US,
    parameter int unsigned MS_US = pps_pkg::US_PER_MS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Pins
    input wire logic button_n,
    input wire logic shutdown_done_n,
    // Extensions in milliseconds
    input wire logic [pps_pkg::EXT_W-1:0] off_debounce_extend,
    input wire logic [pps_pkg::EXT_W-1:0] failsafe_delay_extend,
    // Outputs
    output logic power_en,
    output logic power_off_req_n
);
    import pps_pkg::*;

    logic btn_lvl;
    logic ack_lvl;
    logic [TICK_W-1:0] pre_q;
    logic [TICK_W-1:0] pre_d;
    logic tick;
    pps_state_e st_q;
    pps_state_e st_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic en_q;
    logic en_d;
    logic req_q;
    logic req_d;
    logic [CNT_W-1:0] off_lim;
    logic [CNT_W-1:0] fs_lim;
    logic [CNT_W-1:0] on_last;
    logic [CNT_W-1:0] blank_last;
    logic [CNT_W-1:0] lock_last;
    logic off_done;
    logic fs_done;

    function automatic logic [CNT_W-1:0] lim(input int unsigned base_us,
                                             input logic [EXT_W-1:0] ext_ms);
        lim = CNT_W'(base_us + int'(ext_ms) * MS_US - 1);
    endfunction : lim

    // Last count value of a fixed period given in timebase ticks
    function automatic logic [CNT_W-1:0] last_cnt(input int unsigned period_us);
        last_cnt = CNT_W'(period_us - 1);
    endfunction : last_cnt

    // True on the tick that ends a period
    function automatic logic done(input logic tk, input logic [CNT_W-1:0] cnt,
                                  input logic [CNT_W-1:0] last_v);
        done = tk && (cnt == last_v);
    endfunction : done

    pps_sync u_btn (
        .core_clk(core_clk),
        .nrst(nrst),
        .pin(button_n),
        .level(btn_lvl)
    );

    pps_sync u_ack (
        .core_clk(core_clk),
        .nrst(nrst),
        .pin(shutdown_done_n),
        .level(ack_lvl)
    );

    assign tick = (pre_q == TICK_LAST);
    assign off_lim = lim(OFF_DEB_US, off_debounce_extend);
    assign fs_lim = lim(FAILSAFE_T_US, failsafe_delay_extend);
    assign on_last = last_cnt(ON_DEB_US);
    assign blank_last = last_cnt(BLANK_T_US);
    assign lock_last = last_cnt(LOCKOUT_T_US);
    assign off_done = done(tick, cnt_q, off_lim);
    assign fs_done = done(tick, cnt_q, fs_lim);

    // Timebase prescaler, one tick per microsecond
    always_comb begin
        pre_d = tick ? '0 : pre_q + 1'b1;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_d;
        end
    end

    always_comb begin
        st_d = st_q;
        cnt_d = tick ? cnt_q + 1'b1 : cnt_q;
        en_d = en_q;
        req_d = req_q;
        case (st_q)
            PPS_OFF: begin
                // Idle: wait for a press
                cnt_d = CNT_ZERO;
                if (!btn_lvl) begin
                    st_d = PPS_ON_DEB;
                end
            end
            PPS_ON_DEB: begin
                if (btn_lvl) begin
                    st_d = PPS_OFF;
                    cnt_d = CNT_ZERO;
                end else if (done(tick, cnt_q, on_last)) begin
                    st_d = PPS_BLANK;
                    en_d = 1'b1;
                    cnt_d = CNT_ZERO;
                end
            end
            PPS_BLANK: begin
                // Both inputs ignored until the window closes
                if (done(tick, cnt_q, blank_last)) begin
                    cnt_d = CNT_ZERO;
                    if (!ack_lvl) begin
                        st_d = PPS_LOCKOUT;
                        en_d = 1'b0;
                    end else begin
                        st_d = PPS_RUN;
                    end
                end
            end
            PPS_RUN: begin
                // Powered: the ack takes priority over the button
                cnt_d = CNT_ZERO;
                if (!ack_lvl) begin
                    st_d = PPS_LOCKOUT;
                    en_d = 1'b0;
                end else if (!btn_lvl) begin
                    st_d = PPS_OFF_DEB;
                end
            end
            PPS_OFF_DEB: begin
                if (!ack_lvl) begin
                    st_d = PPS_LOCKOUT;
                    en_d = 1'b0;
                    cnt_d = CNT_ZERO;
                end else if (btn_lvl) begin
                    st_d = PPS_RUN;
                    cnt_d = CNT_ZERO;
                end else if (off_done) begin
                    st_d = PPS_FAILSAFE;
                    req_d = 1'b1;
                    cnt_d = CNT_ZERO;
                end
            end
            PPS_FAILSAFE: begin
                // Wait for the ack or the failsafe expiry
                if (!ack_lvl || fs_done) begin
                    st_d = PPS_LOCKOUT;
                    en_d = 1'b0;
                    req_d = 1'b0;
                    cnt_d = CNT_ZERO;
                end
            end
            PPS_LOCKOUT: begin
                req_d = 1'b0;
                // Button ignored until the converter output has decayed
                if (done(tick, cnt_q, lock_last)) begin
                    st_d = PPS_OFF;
                    cnt_d = CNT_ZERO;
                end
            end
            default: begin
                st_d = PPS_OFF;
                en_d = 1'b0;
                req_d = 1'b0;
                cnt_d = CNT_ZERO;
            end
        endcase
    end

    // State, period counter and output registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= PPS_OFF;
            cnt_q <= CNT_ZERO;
            en_q <= 1'b0;
            req_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            en_q <= en_d;
            req_q <= req_d;
        end
    end

    // Enable polarity follows the variant
    assign power_en = en_q ^ ACTIVE_LOW_EN;
    assign power_off_req_n = ~req_q;
endmodule : pps_top

//--- logic/pps_pkg.sv
// Constants and state encoding for the pushbutton power sequencer
package pps_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned TICK_US = 1;
    localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned ON_DEBOUNCE_MS = 128;
    localparam int unsigned OFF_DEBOUNCE_MS = 32;
    localparam int unsigned BLANK_MS = 512;
    localparam int unsigned FAILSAFE_MS = 128;
    localparam int unsigned LOCKOUT_MS = 256;
    localparam int unsigned ACK_RESP_US = 30;
    localparam int unsigned US_PER_MS = 1000;
    localparam int unsigned ON_DEBOUNCE_US = ON_DEBOUNCE_MS * US_PER_MS;
    localparam int unsigned OFF_DEBOUNCE_US = OFF_DEBOUNCE_MS * US_PER_MS;
    localparam int unsigned BLANK_US = BLANK_MS * US_PER_MS;
    localparam int unsigned FAILSAFE_US = FAILSAFE_MS * US_PER_MS;
    localparam int unsigned LOCKOUT_US = LOCKOUT_MS * US_PER_MS;
    localparam int unsigned EXT_W = 8;
    localparam int unsigned CNT_W = 20;
    localparam int unsigned TICK_W = 6;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
    localparam logic [2:0] SYNC_RESET = 3'h7;

    typedef enum logic [2:0] {
        PPS_OFF = 3'b000,
        PPS_ON_DEB = 3'b001,
        PPS_BLANK = 3'b010,
        PPS_RUN = 3'b011,
        PPS_OFF_DEB = 3'b100,
        PPS_FAILSAFE = 3'b101,
        PPS_LOCKOUT = 3'b110
    } pps_state_e;
endpackage : pps_pkg

//--- logic/pps_sync.sv
// Three-stage input synchroniser with second/third agreement filter
`timescale 1ns/1ps
module pps_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Pin in, filtered level out
    input wire logic pin,
    output logic level
);
    import pps_pkg::*;
    logic [2:0] sh_q;
    logic [2:0] sh_d;
    logic level_q;
    logic level_d;

    always_comb begin
        sh_d = {sh_q[1:0], pin};
        level_d = level_q;
        if (sh_q[1] == sh_q[2]) begin
            level_d = sh_q[2];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sh_q <= SYNC_RESET;
            level_q <= 1'b1;
        end else begin
            sh_q <= sh_d;
            level_q <= level_d;
        end
    end

    assign level = level_q;
endmodule : pps_sync

//--- dv/pps_top_props.sv
// Port checker for the power sequencer
`timescale 1ns/1ps
module pps_top_props #(
    parameter bit ACTIVE_LOW_EN = 1'b0,
    parameter int unsigned ON_DEB_US = 1,
    parameter int unsigned BLANK_T_US = 1,
    parameter int unsigned FAILSAFE_T_US = 1,
    parameter int unsigned MS_US = 1
) (
    // Clock
    input wire logic core_clk,
    input wire logic nrst,
    // Inputs
    input wire logic button_n,
    input wire logic shutdown_done_n,
    input wire logic [pps_pkg::EXT_W-1:0] off_debounce_extend,
    input wire logic [pps_pkg::EXT_W-1:0] failsafe_delay_extend,
    // Outputs
    input wire logic power_en,
    input wire logic power_off_req_n
);
    import pps_pkg::*;
    localparam int ON_C = ON_DEB_US * TICK_CYC;
    localparam int BL_C = BLANK_T_US * TICK_CYC;
    logic [19:0] lo_c, on_c, rq_c;
    int fs_c;
    wire logic en = power_en ^ ACTIVE_LOW_EN;
    assign fs_c = int'((FAILSAFE_T_US + failsafe_delay_extend * MS_US) * TICK_CYC);
    // Cycles of button low, enable on and request active
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lo_c <= 20'h0;
            on_c <= 20'h0;
            rq_c <= 20'h0;
        end else begin
            lo_c <= button_n ? 20'h0 : lo_c + 20'(lo_c != 20'hfffff);
            on_c <= en ? on_c + 20'h1 : 20'h0;
            rq_c <= power_off_req_n ? 20'h0 : rq_c + 20'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_blank_low; on_c == 20'(BL_C - 100) ##0 !shutdown_done_n; endsequence
    property p_req_rel; !en |-> power_off_req_n; endproperty
    a_req_rel: assert property (p_req_rel) else $error("request while off");
    property p_on_deb; $rose(en) |-> lo_c >= ON_C - 60; endproperty
    a_on_deb: assert property (p_on_deb) else $error("enable too early");
    property p_req_src; $fell(power_off_req_n) |-> en && !button_n; endproperty
    a_req_src: assert property (p_req_src) else $error("request without press");
    property p_blank; $fell(en) |-> on_c >= BL_C - 60; endproperty
    a_blank: assert property (p_blank) else $error("release in blanking");
    property p_abort; s_blank_low |-> ##[1:300] !en; endproperty
    a_abort: assert property (p_abort) else $error("no abort");
    property p_ack; !power_off_req_n && $fell(shutdown_done_n) |-> ##[1:10] !en; endproperty
    a_ack: assert property (p_ack) else $error("ack ignored");
    property p_fs_max; rq_c <= fs_c + 100; endproperty
    a_fs_max: assert property (p_fs_max) else $error("failsafe late");
    property p_fs_min;
        $rose(power_off_req_n) && $past(shutdown_done_n) |-> $past(rq_c) >= fs_c - 60;
    endproperty
    a_fs_min: assert property (p_fs_min) else $error("failsafe early");
endmodule : pps_top_props
bind pps_top pps_top_props #(.ACTIVE_LOW_EN(ACTIVE_LOW_EN), .ON_DEB_US(ON_DEB_US),
    .BLANK_T_US(BLANK_T_US), .FAILSAFE_T_US(FAILSAFE_T_US), .MS_US(MS_US))
    pps_top_props_inst (.core_clk(core_clk), .nrst(nrst), .button_n(button_n),
    .shutdown_done_n(shutdown_done_n), .off_debounce_extend(off_debounce_extend),
    .failsafe_delay_extend(failsafe_delay_extend), .power_en(power_en),
    .power_off_req_n(power_off_req_n));

//--- dv/pps_proc.sv
// Processor model on the shutdown handshake
`timescale 1ns/1ps
module pps_proc (
    input wire logic core_clk,
    input wire logic en,
    input wire logic req_n,
    input wire logic [1:0] mode,
    output logic ack_n
);
    initial ack_n = 1'b0;
    // Mode 0 ties request to ack, 1 never raises ack, 2 never answers
    always @(negedge core_clk) begin
        ack_n <= (mode == 2'h1) ? 1'b0 : (mode == 2'h2) ? en : en & req_n;
    end
endmodule : pps_proc

//--- dv/tb_pps_top.sv
// Self-checking bench for the power sequencer
`timescale 1ns/1ps
module tb_pps_top;
    import pps_pkg::*;
    typedef struct {logic [1:0] m; logic [7:0] o; logic [7:0] f;} pps_row_s;
    localparam int ON = 20, OFF = 10, BL = 30, FS = 20, LK = 15, MS = 2, T = TICK_CYC;
    pps_row_s rows[4] = '{'{2'h0, 8'h00, 8'h00}, '{2'h0, 8'hff, 8'h00},
        '{2'h2, 8'h00, 8'hff}, '{2'h1, 8'h00, 8'h00}};
    logic core_clk, nrst, button_n, ack_n, en, req_n;
    logic [1:0] mode = 2'h0;
    logic [7:0] oext = 8'h00, fext = 8'h00;
    int n_fail = 0, tests_run = 0, cyc;
    pps_top #(.ON_DEB_US(ON), .OFF_DEB_US(OFF), .BLANK_T_US(BL), .FAILSAFE_T_US(FS),
        .LOCKOUT_T_US(LK), .MS_US(MS)) pps_top_inst (.core_clk(core_clk), .nrst(nrst),
        .button_n(button_n), .shutdown_done_n(ack_n), .off_debounce_extend(oext),
        .failsafe_delay_extend(fext), .power_en(en), .power_off_req_n(req_n));
    pps_proc pps_proc_inst (.core_clk(core_clk), .en(en), .req_n(req_n), .mode(mode),
        .ack_n(ack_n));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    function automatic logic near(input int c, input int e);
        return c >= e - 120 && c <= e + 120;
    endfunction : near
    task automatic check(input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %b expected %b", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    // Count falling edges until enable or request reaches val
    task automatic wait_on(input logic val, input logic sel, input int lim);
        cyc = 0;
        while ((sel ? req_n : en) !== val) begin
            @(negedge core_clk);
            cyc++;
            if (cyc > lim) begin
                n_fail++;
                report_and_stop();
            end
        end
    endtask : wait_on
    task automatic do_reset;
        nrst = 1'b0;
        button_n = 1'b1;
        repeat (5) @(negedge core_clk);
        check(en | ~req_n, 1'b0);
        nrst = 1'b1;
    endtask : do_reset
    initial begin
        foreach (rows[i]) begin
            do_reset();
            {mode, oext, fext} = {rows[i].m, rows[i].o, rows[i].f};
            @(negedge core_clk);
            button_n = 1'b0;
            wait_on(1'b1, 1'b0, 9000);
            check(near(cyc, ON * T), 1'b1);
            if (mode == 2'h1) begin
                wait_on(1'b0, 1'b0, 9000);
                check(near(cyc, BL * T), 1'b1);
            end else begin
                wait_on(1'b0, 1'b1, 90000);
                check(near(cyc, (BL + OFF + oext * MS) * T), 1'b1);
                wait_on(1'b0, 1'b0, 90000);
                check(near(cyc, mode == 2'h0 ? 5 : (FS + fext * MS) * T), 1'b1);
                check(req_n, 1'b1);
            end
            wait_on(1'b1, 1'b0, 9000);
            check(near(cyc, (LK + ON) * T), 1'b1);
            $display("Row %0d done", i);
        end
        do_reset();
        @(negedge core_clk);
        button_n = 1'b0;
        repeat (ON * T - 200) @(negedge core_clk);
        button_n = 1'b1;
        repeat (20) @(negedge core_clk);
        button_n = 1'b0;
        wait_on(1'b1, 1'b0, 9000);
        check(near(cyc, ON * T), 1'b1);
        $display("Debounce restart done");
        report_and_stop();
    end
endmodule : tb_pps_top
